// ---- design/soft_reset_policy.sv ----
/*
 Soft reset handling of a power delivery policy engine, for source
 and sink roles: initiating a soft reset after errors, answering a
 received one, and falling back to a hard reset.
 Assumes one-cycle event pulses from a protocol layer on this clock,
 and that the rest of the engine acts on the one-cycle exit pulses.
*/
`timescale 1ns/1ps
`include "srp_params.svh"
// Summary of operation
// - Source enters initiate state on protocol error or send failure after retries.
// - Failing to send the soft reset itself never starts another soft reset.
// - Send-caps failure while detached goes to discovery, not soft reset.
// - Errors during power role swap supply transition trigger hard reset directly.
// - Errors during data role change trigger connector error recovery directly.
// - Source initiate: reset protocol layer, send soft reset, start response timer.
// - Accept in source initiate state leads to source send-capabilities.
// - Timer expiry or transmit error in source initiate leads to hard reset.
// - Provider picks source hard reset; consumer/provider picks sink hard reset.
// - Source enters respond state from any state on received soft reset.
// - Respond state: reset protocol layer, then request an accept be sent.
// - Accept sent from source respond state leads to source send-capabilities.
// - Transmit error in respond state leads to role-selected hard reset.
// - Sink enters initiate state on errors, except role swap cases only.
// - Sink initiate: reset protocol layer, send soft reset, start response timer.
// - Accept in sink initiate state leads to sink wait-for-capabilities.
// - Timer expiry or transmit error in sink initiate leads to hard reset.
// - Sink respond state sends accept, then goes to sink wait-for-capabilities.
// - Sink hard reset requests phy hard reset signalling, increments counter.
module soft_reset_policy
   import srp_pkg::*;
#(
   parameter int TIMER_W = `TIMER_W,
   parameter int HR_COUNT_W = `HR_COUNT_W,
   parameter logic [TIMER_W-1:0] SENDER_RESP_CYCLES = TIMER_W'(`SENDER_RESP_CYCLES)
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Protocol layer events and engine context
   input wire srp_pkg::proto_evt_t evt,
   input wire srp_pkg::pe_ctx_t ctx,
   // Hard reset counter clear (detach or power cycle)
   input wire logic hr_count_clear,
   // Requests to the protocol layer
   output srp_pkg::proto_req_t req_ff,
   // Exit pulses to the policy engine
   output srp_pkg::pe_exit_t exit_ff,
   // Status
   output srp_pkg::srp_state_t state_ff,
   output logic [HR_COUNT_W-1:0] hard_reset_counter_b_ff
);
   import srp_pkg::*;

   srp_state_t nxt_state;
   proto_req_t nxt_req;
   pe_exit_t nxt_exit;
   logic timer_start;
   logic timer_stop;
   logic timer_expired;
   logic in_initiate_wait;
   logic in_soft_reset;
   logic error_evt;

   // Hard reset target by default role
   function automatic pe_exit_t hard_reset_exit(input logic default_role);
      pe_exit_t e;
      e = '0;
      if (default_role == `ROLE_CONS_PROV)
      begin
         e.go_sink_hard_reset = 1'b1;
         e.phy_hard_reset_req = 1'b1;
      end
      else
         e.go_source_hard_reset = 1'b1;
      return e;
   endfunction : hard_reset_exit

   assign in_initiate_wait = (state_ff == st_src_sr_init_wait) || (state_ff == st_snk_sr_init_wait);
   assign in_soft_reset = (state_ff != st_idle);
   // Send failure inside a soft reset is handled there, not as a new error
   assign error_evt = evt.protocol_error || (evt.send_failed && !in_soft_reset);

   sender_response_timer #(
      .TIMER_W(TIMER_W),
      .LOAD(SENDER_RESP_CYCLES)
   ) u_sender_response_timer_a (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(timer_start),
      .stop(timer_stop),
      .expired_ff(timer_expired),
      .running_ff()
   );

   // Timer starts once the soft reset message has gone out
   assign timer_start = (state_ff == st_src_sr_init_send || state_ff == st_snk_sr_init_send)
      && evt.msg_sent;
   // Stopped on any response or on leaving the wait state
   assign timer_stop = in_initiate_wait && (nxt_state != state_ff);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_req = '0;
      nxt_exit = '0;
      if (evt.soft_reset_rx)
      begin
         // Partner soft reset wins over everything else
         nxt_state = ctx.power_role_source ? st_src_sr_resp_reset : st_snk_sr_resp_reset;
         nxt_req.proto_soft_reset = 1'b1;
      end
      else if (!in_soft_reset && error_evt)
      begin
         if (ctx.prs_supply_transition)
            nxt_exit = hard_reset_exit(ctx.default_role);
         else if (ctx.drs_role_change)
            nxt_exit.go_error_recovery = 1'b1;
         else if (ctx.power_role_source && ctx.in_send_caps && evt.send_failed && !ctx.attached)
            nxt_exit.go_source_discovery = 1'b1;
         else if (ctx.power_role_source)
         begin
            nxt_state = st_src_sr_init_reset;
            nxt_req.proto_soft_reset = 1'b1;
         end
         else
         begin
            nxt_state = st_snk_sr_init_reset;
            nxt_req.proto_soft_reset = 1'b1;
         end
      end
      else
      begin
         case (state_ff)
            st_idle:
            begin
               nxt_state = st_idle;
            end
            st_src_sr_init_reset:
            begin
               nxt_state = st_src_sr_init_send;
               nxt_req.send_soft_reset = 1'b1;
            end
            st_snk_sr_init_reset:
            begin
               nxt_state = st_snk_sr_init_send;
               nxt_req.send_soft_reset = 1'b1;
            end
            st_src_sr_init_send, st_snk_sr_init_send:
            begin
               if (evt.tx_error || evt.send_failed)
               begin
                  nxt_state = st_idle;
                  nxt_exit = hard_reset_exit(ctx.default_role);
               end
               else if (evt.msg_sent)
                  nxt_state = (state_ff == st_src_sr_init_send) ? st_src_sr_init_wait : st_snk_sr_init_wait;
            end
            st_src_sr_init_wait, st_snk_sr_init_wait:
            begin
               if (evt.accept_rx)
               begin
                  nxt_state = st_idle;
                  if (state_ff == st_src_sr_init_wait)
                     nxt_exit.go_source_send_caps = 1'b1;
                  else
                     nxt_exit.go_sink_wait_caps = 1'b1;
               end
               else if (timer_expired || evt.tx_error)
               begin
                  // Partner missed its accept deadline, or a transmit error was reported
                  nxt_state = st_idle;
                  nxt_exit = hard_reset_exit(ctx.default_role);
               end
            end
            st_src_sr_resp_reset:
            begin
               nxt_state = st_src_sr_resp_send;
               nxt_req.send_accept = 1'b1;
            end
            st_snk_sr_resp_reset:
            begin
               nxt_state = st_snk_sr_resp_send;
               nxt_req.send_accept = 1'b1;
            end
            st_src_sr_resp_send, st_snk_sr_resp_send, st_src_sr_resp_wait, st_snk_sr_resp_wait:
            begin
               if (evt.tx_error || evt.send_failed)
               begin
                  nxt_state = st_idle;
                  nxt_exit = hard_reset_exit(ctx.default_role);
               end
               else if (evt.msg_sent)
               begin
                  nxt_state = st_idle;
                  if (state_ff == st_src_sr_resp_send || state_ff == st_src_sr_resp_wait)
                     nxt_exit.go_source_send_caps = 1'b1;
                  else
                     nxt_exit.go_sink_wait_caps = 1'b1;
               end
            end
            default:
            begin
               nxt_state = st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         state_ff <= st_idle;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         req_ff <= '0;
         exit_ff <= '0;
      end
      else
      begin
         req_ff <= nxt_req;
         exit_ff <= nxt_exit;
      end
   end

   // Saturates rather than wrapping so a stuck partner stays visible
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         hard_reset_counter_b_ff <= '0;
      // A hard reset in the clear cycle still counts
      else if (hr_count_clear)
         hard_reset_counter_b_ff <= nxt_exit.go_sink_hard_reset ? HR_COUNT_W'(1) : '0;
      else if (nxt_exit.go_sink_hard_reset && !(&hard_reset_counter_b_ff))
         hard_reset_counter_b_ff <= hard_reset_counter_b_ff + HR_COUNT_W'(1);
   end
endmodule : soft_reset_policy

// ---- design/srp_params.svh ----
/*
 Timing and encoding constants for the soft reset policy engine.
 Assumes a 200 MHz clock; included by the package users by bare name.
*/
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH
`define CLK_PERIOD_NS 5
`define SENDER_RESP_TIME_US 27
`define SENDER_RESP_CYCLES ((`SENDER_RESP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define TIMER_W 16
`define HR_COUNT_W 4
`define ROLE_PROVIDER 1'b0
`define ROLE_CONS_PROV 1'b1
`endif

// ---- design/srp_pkg.sv ----
/*
 Types for the soft reset policy engine: events from the protocol layer,
 state exits toward the policy engine, and the engine states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package srp_pkg;
   typedef enum logic [3:0] {
      st_idle,
      st_src_sr_init_reset,
      st_src_sr_init_send,
      st_src_sr_init_wait,
      st_src_sr_resp_reset,
      st_src_sr_resp_send,
      st_src_sr_resp_wait,
      st_snk_sr_init_reset,
      st_snk_sr_init_send,
      st_snk_sr_init_wait,
      st_snk_sr_resp_reset,
      st_snk_sr_resp_send,
      st_snk_sr_resp_wait
   } srp_state_t;

   // Single-cycle events from the local protocol layer
   typedef struct packed {
      logic protocol_error;
      logic send_failed;
      logic soft_reset_rx;
      logic accept_rx;
      logic msg_sent;
      logic tx_error;
   } proto_evt_t;

   // Context from the rest of the policy engine
   typedef struct packed {
      logic power_role_source;
      logic in_send_caps;
      logic attached;
      logic prs_supply_transition;
      logic drs_role_change;
      logic default_role;
   } pe_ctx_t;

   // Requests toward the protocol layer
   typedef struct packed {
      logic proto_soft_reset;
      logic send_soft_reset;
      logic send_accept;
   } proto_req_t;

   // State exits toward the policy engine
   typedef struct packed {
      logic go_source_send_caps;
      logic go_sink_wait_caps;
      logic go_source_hard_reset;
      logic go_sink_hard_reset;
      logic go_source_discovery;
      logic go_error_recovery;
      logic phy_hard_reset_req;
   } pe_exit_t;
endpackage : srp_pkg

// ---- design/sender_response_timer.sv ----
/*
 Sender response timer: loads on start, counts down, pulses on expiry.
 Assumes start and stop are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`include "srp_params.svh"
module sender_response_timer #(
   parameter int TIMER_W = `TIMER_W,
   parameter logic [TIMER_W-1:0] LOAD = TIMER_W'(`SENDER_RESP_CYCLES)
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Control
   input wire logic start,
   input wire logic stop,
   // Status
   output logic expired_ff,
   output logic running_ff
);
   logic [TIMER_W-1:0] count_ff;

   always_ff @(posedge clock)
   begin
      if (sys_rst || stop)
      begin
         count_ff <= '0;
         running_ff <= 1'b0;
      end
      else if (start)
      begin
         count_ff <= LOAD;
         running_ff <= 1'b1;
      end
      else if (running_ff)
      begin
         count_ff <= count_ff - TIMER_W'(1);
         if (count_ff == TIMER_W'(1))
            running_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst || stop || start)
         expired_ff <= 1'b0;
      else
         expired_ff <= running_ff && (count_ff == TIMER_W'(1));
   end
endmodule : sender_response_timer

// ---- verification/srp_checker_sva.sv ----
/*
 Checker for the soft reset policy engine, bound to its top ports.
 Assumes events arrive as one-cycle pulses, mostly while idle.
*/
`timescale 1ns/1ps
module srp_checker_sva
   import srp_pkg::*;
#(
   parameter int TIMER_W = 16,
   parameter int HR_COUNT_W = 4,
   parameter logic [TIMER_W-1:0] SENDER_RESP_CYCLES = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Inputs
   input wire srp_pkg::proto_evt_t evt,
   input wire srp_pkg::pe_ctx_t ctx,
   input wire logic hr_count_clear,
   // Outputs
   input wire srp_pkg::proto_req_t req_ff,
   input wire srp_pkg::pe_exit_t exit_ff,
   input wire srp_pkg::srp_state_t state_ff,
   input wire logic [HR_COUNT_W-1:0] hard_reset_counter_b_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [TIMER_W:0] wait_cnt_ff;
   wire idle = state_ff == st_idle;
   wire errs = evt.protocol_error | evt.send_failed;
   wire quiet = !evt.soft_reset_rx;
   wire plain = !ctx.prs_supply_transition && !ctx.drs_role_change;
   wire in_wait = state_ff inside {st_src_sr_init_wait, st_snk_sr_init_wait};
   wire in_send = state_ff inside {st_src_sr_init_send, st_snk_sr_init_send};
   wire in_resp = state_ff inside {st_src_sr_resp_send, st_snk_sr_resp_send};
   // Dwell time in a wait state; a timer that never fires shows here
   always_ff @(posedge clock)
   begin
      if (sys_rst || !in_wait)
         wait_cnt_ff <= '0;
      else
         wait_cnt_ff <= wait_cnt_ff + 1'b1;
   end
   a_init_start: assert property (idle && evt.protocol_error && plain && quiet |=> req_ff.proto_soft_reset &&
      state_ff == ($past(ctx.power_role_source) ? st_src_sr_init_reset : st_snk_sr_init_reset))
      else $error("soft reset not started");
   a_init_send: assert property (state_ff inside {st_src_sr_init_reset, st_snk_sr_init_reset} && quiet
      |=> req_ff.send_soft_reset) else $error("soft reset message not requested");
   a_accept_req: assert property (state_ff inside {st_src_sr_resp_reset, st_snk_sr_resp_reset} && quiet
      |=> req_ff.send_accept) else $error("accept not requested");
   a_respond_entry: assert property (evt.soft_reset_rx |=> req_ff.proto_soft_reset &&
      state_ff == ($past(ctx.power_role_source) ? st_src_sr_resp_reset : st_snk_sr_resp_reset))
      else $error("respond state not entered");
   a_no_retrigger: assert property (in_send && (evt.tx_error || evt.send_failed) && quiet
      |=> !req_ff.proto_soft_reset && idle) else $error("soft reset retriggered");
   a_detached_disc: assert property (idle && evt.send_failed && ctx.power_role_source && ctx.in_send_caps &&
      !ctx.attached && plain && quiet |=> exit_ff.go_source_discovery && !req_ff.proto_soft_reset)
      else $error("discovery not taken");
   a_swap_hard: assert property (idle && errs && ctx.prs_supply_transition && quiet
      |=> (exit_ff.go_source_hard_reset || exit_ff.go_sink_hard_reset) && !req_ff.proto_soft_reset)
      else $error("swap error not hard reset");
   a_role_recover: assert property (idle && errs && ctx.drs_role_change && !ctx.prs_supply_transition && quiet
      |=> exit_ff.go_error_recovery ##1 idle) else $error("error recovery missing");
   a_accept_exit: assert property (in_wait && evt.accept_rx && !evt.tx_error && quiet
      |=> exit_ff.go_source_send_caps == ($past(state_ff) == st_src_sr_init_wait) &&
      exit_ff.go_sink_wait_caps == ($past(state_ff) == st_snk_sr_init_wait)) else $error("accept exit wrong");
   a_hard_role: assert property ((in_wait || in_send || in_resp) && evt.tx_error && quiet
      |=> exit_ff.go_sink_hard_reset == $past(ctx.default_role) &&
      exit_ff.go_source_hard_reset != $past(ctx.default_role)) else $error("hard reset role wrong");
   a_timer_bound: assert property (in_wait |-> wait_cnt_ff <= SENDER_RESP_CYCLES + 2)
      else $error("response timer overrun");
   a_resp_done: assert property (in_resp && evt.msg_sent && !evt.tx_error && quiet
      |=> exit_ff.go_source_send_caps == ($past(state_ff) == st_src_sr_resp_send) &&
      exit_ff.go_sink_wait_caps == ($past(state_ff) == st_snk_sr_resp_send)) else $error("respond exit wrong");
   a_hr_count: assert property (exit_ff.go_sink_hard_reset && !$past(hr_count_clear) &&
      $past(hard_reset_counter_b_ff) != '1 |-> exit_ff.phy_hard_reset_req &&
      hard_reset_counter_b_ff == $past(hard_reset_counter_b_ff) + 1'b1) else $error("hard reset count wrong");
   c_caps: cover property (exit_ff.go_source_send_caps);
   c_sink_hard: cover property (exit_ff.go_sink_hard_reset);
   c_discovery: cover property (exit_ff.go_source_discovery);
endmodule : srp_checker_sva

// ---- verification/link_partner_model.sv ----
/*
 Partner model: completes sends and answers a soft reset.
 Assumes mode 0 prompt accept, 1 slow, 2 silent, 3 failed soft reset send or accept transmit error.
*/
`timescale 1ns/1ps
module link_partner_model
   import srp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Behaviour and requests
   input wire logic [1:0] mode,
   input wire srp_pkg::proto_req_t req,
   // Events back to the engine
   output srp_pkg::proto_evt_t evt
);
   import srp_pkg::*;
   logic [3:0] cnt_ff;
   logic sr_ff;
   always_ff @(posedge clock)
   begin
      evt <= '0;
      if (sys_rst)
         cnt_ff <= 4'h0;
      else if (req.send_soft_reset || req.send_accept)
         cnt_ff <= 4'h9;
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h8)
      begin
         evt.msg_sent <= mode != 2'h3;
         // Soft reset send fails outright, accept send hits a transmit error
         evt.send_failed <= (mode == 2'h3) && sr_ff;
         evt.tx_error <= (mode == 2'h3) && !sr_ff;
      end
      // Slow answer still lands inside the initiator's timer
      if (sr_ff && cnt_ff == (mode == 2'h0 ? 4'h6 : 4'h1))
         evt.accept_rx <= mode < 2'h2;
   end
   always_ff @(posedge clock)
   begin
      if (req.send_soft_reset || req.send_accept)
         sr_ff <= req.send_soft_reset;
   end
endmodule : link_partner_model

// ---- verification/tb_top.sv ----
/*
 Testbench for the soft reset policy engine with a partner model.
 Assumes a short response timer of 8 cycles.
*/
`timescale 1ns/1ps
module tb_top;
   import srp_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic hr_count_clear = 1'b0;
   logic [1:0] mode = 2'h0;
   proto_evt_t evt_tb = '0;
   proto_evt_t evt_p;
   proto_evt_t evt;
   pe_ctx_t ctx = '0;
   proto_req_t req_ff;
   pe_exit_t exit_ff;
   srp_state_t state_ff;
   logic [3:0] cnt;
   logic [3:0] exp_cnt = 4'h0;
   pe_exit_t exp_q[$];
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 31;
   logic r;
   assign evt = evt_tb | evt_p;
   always #2.5 clock = ~clock;
   soft_reset_policy #(.SENDER_RESP_CYCLES(16'h0008)) soft_reset_policy_inst (.clock(clock), .sys_rst(sys_rst),
      .evt(evt), .ctx(ctx), .hr_count_clear(hr_count_clear), .req_ff(req_ff), .exit_ff(exit_ff),
      .state_ff(state_ff), .hard_reset_counter_b_ff(cnt));
   link_partner_model link_partner_model_inst (.clock(clock), .sys_rst(sys_rst), .mode(mode), .req(req_ff),
      .evt(evt_p));
   function automatic pe_exit_t hr(input logic rr);
      return rr ? 7'h09 : 7'h10;
   endfunction : hr
   task automatic cmp_exit(input pe_exit_t got, input pe_exit_t exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_exit
   task automatic cmp_cnt(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_cnt
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic run(input pe_ctx_t c, input proto_evt_t e, input logic [1:0] m, input pe_exit_t x);
      int n;
      n = 0;
      ctx <= c;
      mode <= m;
      @(posedge clock);
      evt_tb <= e;
      exp_q.push_back(x);
      @(posedge clock);
      evt_tb <= '0;
      while (exp_q.size() != 0 && n < 40)
      begin
         @(posedge clock);
         n++;
      end
      if (n == 40)
         errors++;
      repeat (3) @(posedge clock);
      if (x.go_sink_hard_reset)
         exp_cnt = exp_cnt + 4'h1;
      cmp_cnt(cnt, exp_cnt);
      $display("test done, exit %h", x);
   endtask : run
   always @(negedge clock)
   begin
      if (!sys_rst && exit_ff !== '0)
         cmp_exit(exit_ff, exp_q.pop_front());
   end
   // Hang guard sized well above the whole sequence
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 2; i++)
      begin
         r = $random(seed);
         run({5'h14, r}, 6'h20, 2'h0, 7'h40);
         run({5'h14, r}, 6'h10, 2'h1, 7'h40);
         run({5'h14, r}, 6'h20, 2'h2, hr(r));
         run({5'h14, r}, 6'h20, 2'h3, hr(r));
         run({5'h18, r}, 6'h10, 2'h0, 7'h04);
         run({5'h16, r}, 6'h20, 2'h0, hr(r));
         run({5'h15, r}, 6'h10, 2'h0, 7'h02);
         run({5'h14, r}, 6'h08, 2'h0, 7'h40);
         run({5'h14, r}, 6'h08, 2'h3, hr(r));
         run({5'h04, r}, 6'h20, 2'h0, 7'h20);
         run({5'h04, r}, 6'h10, 2'h2, hr(r));
         run({5'h04, r}, 6'h08, 2'h0, 7'h20);
         run({5'h08, r}, 6'h10, 2'h1, 7'h20);
      end
      hr_count_clear <= 1'b1;
      @(posedge clock);
      hr_count_clear <= 1'b0;
      exp_cnt = 4'h0;
      repeat (2) @(posedge clock);
      cmp_cnt(cnt, exp_cnt);
      finish_test();
   end
endmodule : tb_top
bind soft_reset_policy srp_checker_sva #(.TIMER_W(TIMER_W), .HR_COUNT_W(HR_COUNT_W),
   .SENDER_RESP_CYCLES(SENDER_RESP_CYCLES)) srp_checker_sva_inst (.clock(clock), .sys_rst(sys_rst), .evt(evt),
   .ctx(ctx), .hr_count_clear(hr_count_clear), .req_ff(req_ff), .exit_ff(exit_ff), .state_ff(state_ff),
   .hard_reset_counter_b_ff(hard_reset_counter_b_ff));
